/* File: rtl/lms_on_stretch.sv */
// Holds a column sink on for a programmable number of cycles after its request drops.
module lms_on_stretch (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       req,
	input  wire logic [9:0] extendCycles,
	output logic            on
);
	logic [9:0] holdCnt_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			holdCnt_r <= 10'h000;
		end else if (req) begin
			holdCnt_r <= extendCycles;
		end else if (holdCnt_r != 10'h000) begin
			holdCnt_r <= holdCnt_r - 10'h001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			on <= 1'b0;
		end else begin
			on <= req | (holdCnt_r != 10'h000);
		end
	end
endmodule

/* File: rtl/lms_pkg.sv */
// Constants, types and helper functions shared by the LED matrix scan controller.
package lms_pkg;
	localparam logic [7:0] ADDR_ROW_FORCE_UPPER = 8'h2f;
	localparam logic [7:0] ADDR_ROW_MASK_LOWER  = 8'h30;
	localparam logic [7:0] ADDR_ROW_MASK_UPPER  = 8'h31;
	localparam logic [7:0] ADDR_SLOPE_TIME      = 8'h32;
	localparam logic [7:0] ADDR_MELODY_COMP     = 8'h33;
	localparam logic [7:0] ADDR_SCAN_COUNT      = 8'h36;
	localparam logic [7:0] ADDR_DUTY_FIRST      = 8'h40;
	localparam logic [7:0] ADDR_DUTY_LAST       = 8'h90;
	localparam logic [7:0] ADDR_BRIGHT_FIRST    = 8'h91;
	localparam logic [7:0] ADDR_BRIGHT_LAST     = 8'he1;

	localparam logic [2:0] RST_ROW_FORCE_UPPER = 3'h0;
	localparam logic [5:0] RST_ROW_MASK_LOWER  = 6'h00;
	localparam logic [2:0] RST_ROW_MASK_UPPER  = 3'h0;
	localparam logic [4:0] RST_SLOPE_TIME      = 5'h00;
	localparam logic [2:0] RST_MELODY_COMP     = 3'h3;
	localparam logic [3:0] RST_SCAN_COUNT      = 4'h8;
	localparam logic [7:0] RST_DUTY            = 8'h00;
	localparam logic [7:0] RST_BRIGHT          = 8'h00;

	localparam int FADE_DOUBLE_BIT = 4;
	localparam int LOW_EXT_LSB     = 2;
	localparam int HIGH_EXT_LSB    = 0;
	localparam int BRIGHT_LSB      = 4;
	localparam int STEP_LSB        = 0;

	localparam int         LED_COUNT  = 81;
	localparam int         LINE_COUNT = 9;
	localparam logic [3:0] SCAN_ALL   = 4'h8;

	localparam logic [7:0] LINE_CLKS  = 8'hff;
	localparam logic [7:0] BLANK_CLKS = 8'h04;

	localparam int CORE_CLK_KHZ   = 40000;
	localparam int CORE_PERIOD_NS = 25;
	localparam int INT_CLK_KHZ    = 2400;
	localparam int INT_TICK_DIV   = CORE_CLK_KHZ / INT_CLK_KHZ;
	localparam int INT_PERIOD_NS  = 1000000 / INT_CLK_KHZ;
	localparam int COMP_STEP_NS   = 1940;
	localparam int COMP_STEP_CYC  = (COMP_STEP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int STEP_UNIT_NS   = 1939000;
	localparam int STEP_UNIT_FRAMES =
		STEP_UNIT_NS / (LINE_COUNT * 255 * INT_PERIOD_NS);

	typedef enum logic [1:0] {PH_RISE, PH_HIGH, PH_FALL, PH_LOW} lms_phase_e;

	// Step length of one fade code in scan frames; a frame shrinks with fewer lines scanned.
	function automatic logic [5:0] lms_step_frames(input logic [2:0] code);
		logic [3:0] mult;
		case (code)
			3'h0: mult = 4'h0;
			3'h1: mult = 4'h1;
			3'h2: mult = 4'h2;
			3'h3: mult = 4'h4;
			3'h4: mult = 4'h6;
			3'h5: mult = 4'h8;
			3'h6: mult = 4'ha;
			default: mult = 4'hc;
		endcase
		return 6'(int'(mult) * STEP_UNIT_FRAMES);
	endfunction

	function automatic logic [5:0] lms_scale(input logic [5:0] t1, input logic [1:0] sel);
		logic [5:0] v;
		case (sel)
			2'b00: v = t1;
			2'b01: v = t1 >> 2;
			2'b10: v = t1 >> 1;
			default: v = t1 << 1;
		endcase
		return (v == 6'h00) ? 6'h01 : v;
	endfunction
endpackage

/* File: rtl/lms_scan_ctrl.sv */
// LED matrix scan controller: registers, row scan, per-LED PWM, fade and firefly.
// Overview of operation
// - Row 7 to 9 force bits hold that row supply switch on.
// - Row 1 to 6 mask bits hold that row supply switch off.
// - Row 7 to 9 mask bits hold that row supply switch off.
// - Fade-out bit makes fade-out interval equal or twice the base step time.
// - Low-slope field sets low hold to base, quarter, half or double.
// - High-slope field sets high hold to base, quarter, half or double.
// - Melody compensation stretches turn-on by about 1.94 us per code; resets to 3.
// - Scan count code n scans the first n+1 lines; code 8 scans all.
// - Scan count codes above 8 scan all lines.
// - Duty value gives that many on ticks per 255-tick line (at most 251); reset zero.
// - Duty only acts while the LED PWM enable is set.
// - Duty registers for all LEDs sit at consecutive addresses.
// - Upper nibble of brightness register selects LED current code linearly.
// - Step code sets fade step time; code zero changes duty at once.
// - With PWM disabled a nonzero step code runs firefly breathing.
// - Fades move duty one code per step interval.
// - Step time scales in proportion to the number of lines scanned.
// - Brightness and step registers for all LEDs sit at consecutive addresses.
// - Mode priority: off, column constant, row mask, row force, PWM, blink, constant.
// - Lines scan one at a time, 255 ticks each, first 4 ticks blank.
// - Timing runs from internal 2.5 MHz ticks (core clock divided by 16) unless external clock selected.
module lms_scan_ctrl (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        regWrEn,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	output logic      [7:0]  regRdData,
	input  wire logic        matrixEnable,
	input  wire logic [8:0]  colConstMode,
	input  wire logic [80:0] ledPwmEnable,
	input  wire logic        extClkSel,
	input  wire logic        extClkIn,
	input  wire logic        melodyMode,
	output logic      [8:0]  rowSwitchOn,
	output logic      [8:0]  colSinkOn,
	output logic      [35:0] colCurrentCode
);
	localparam int LC = lms_pkg::LINE_COUNT;
	localparam int LN = lms_pkg::LED_COUNT;

	logic [2:0] rowForceUpper_r;
	logic [5:0] rowMaskLower_r;
	logic [2:0] rowMaskUpper_r;
	logic [4:0] slopeCtrl_r;
	logic [2:0] melodyComp_r;
	logic [3:0] scanCount_r;
	logic [7:0] dutyMem [LN];
	logic [7:0] brightMem [LN];

	logic [8:0] rowForceAct_r;
	logic [8:0] rowMaskAct_r;
	logic [4:0] slopeAct_r;
	logic [2:0] melodyAct_r;
	logic [3:0] scanLast_r;
	logic [3:0] scanLast_nxt;
	logic [3:0] scanIdx_r;
	logic [3:0] scanIdx_nxt;
	logic [7:0] lineCnt_r;
	logic       tick;
	logic       lineEnd;
	logic       blank;
	logic [6:0] lineBase;
	logic [6:0] nextBase;

	logic [7:0]              curDuty_r [LN];
	logic [5:0]              stepCnt_r [LN];
	lms_pkg::lms_phase_e     phase_r [LN];
	logic [7:0]              curDuty_nxt [LC];
	logic [5:0]              stepCnt_nxt [LC];
	lms_pkg::lms_phase_e     phase_nxt [LC];
	logic [5:0]              baseSteps [LC];
	logic [5:0]              waitLen [LC];
	logic [8:0]              sinkReq;
	logic [9:0]              extendCycles;

	wire logic isDuty = (regAddr >= lms_pkg::ADDR_DUTY_FIRST) &&
		(regAddr <= lms_pkg::ADDR_DUTY_LAST);
	wire logic isBright = (regAddr >= lms_pkg::ADDR_BRIGHT_FIRST) &&
		(regAddr <= lms_pkg::ADDR_BRIGHT_LAST);
	wire logic [6:0] dutyIdx = 7'(regAddr - lms_pkg::ADDR_DUTY_FIRST);
	wire logic [6:0] brightIdx = 7'(regAddr - lms_pkg::ADDR_BRIGHT_FIRST);

	lms_tick_gen u_tick (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.extClkSel (extClkSel),
		.extClkIn  (extClkIn),
		.tick      (tick)
	);

	// Control register writes; unused bit positions are simply not stored.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rowForceUpper_r <= lms_pkg::RST_ROW_FORCE_UPPER;
			rowMaskLower_r  <= lms_pkg::RST_ROW_MASK_LOWER;
			rowMaskUpper_r  <= lms_pkg::RST_ROW_MASK_UPPER;
			slopeCtrl_r     <= lms_pkg::RST_SLOPE_TIME;
			melodyComp_r    <= lms_pkg::RST_MELODY_COMP;
			scanCount_r     <= lms_pkg::RST_SCAN_COUNT;
		end else if (regWrEn) begin
			case (regAddr)
				lms_pkg::ADDR_ROW_FORCE_UPPER: rowForceUpper_r <= regWrData[2:0];
				lms_pkg::ADDR_ROW_MASK_LOWER: rowMaskLower_r <= regWrData[5:0];
				lms_pkg::ADDR_ROW_MASK_UPPER: rowMaskUpper_r <= regWrData[2:0];
				lms_pkg::ADDR_SLOPE_TIME: slopeCtrl_r <= regWrData[4:0];
				lms_pkg::ADDR_MELODY_COMP: melodyComp_r <= regWrData[2:0];
				lms_pkg::ADDR_SCAN_COUNT: scanCount_r <= regWrData[3:0];
				default: ;
			endcase
		end
	end

	// Per-LED duty and brightness words at consecutive addresses.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < LN; i++) begin
				dutyMem[i]   <= lms_pkg::RST_DUTY;
				brightMem[i] <= lms_pkg::RST_BRIGHT;
			end
		end else if (regWrEn && isDuty) begin
			dutyMem[dutyIdx] <= regWrData;
		end else if (regWrEn && isBright) begin
			brightMem[brightIdx] <= regWrData & 8'hf7;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 8'h00;
		end else if (isDuty) begin
			regRdData <= dutyMem[dutyIdx];
		end else if (isBright) begin
			regRdData <= brightMem[brightIdx];
		end else begin
			case (regAddr)
				lms_pkg::ADDR_ROW_FORCE_UPPER: regRdData <= {5'h00, rowForceUpper_r};
				lms_pkg::ADDR_ROW_MASK_LOWER: regRdData <= {2'h0, rowMaskLower_r};
				lms_pkg::ADDR_ROW_MASK_UPPER: regRdData <= {5'h00, rowMaskUpper_r};
				lms_pkg::ADDR_SLOPE_TIME: regRdData <= {3'h0, slopeCtrl_r};
				lms_pkg::ADDR_MELODY_COMP: regRdData <= {5'h00, melodyComp_r};
				lms_pkg::ADDR_SCAN_COUNT: regRdData <= {4'h0, scanCount_r};
				default: regRdData <= 8'h00;
			endcase
		end
	end

	assign lineEnd = tick && (lineCnt_r == lms_pkg::LINE_CLKS - 8'h01);
	assign blank = (lineCnt_r < lms_pkg::BLANK_CLKS);
	assign scanLast_nxt = (scanCount_r >= lms_pkg::SCAN_ALL) ? lms_pkg::SCAN_ALL : scanCount_r;
	assign scanIdx_nxt = (scanIdx_r >= scanLast_r) ? 4'h0 : scanIdx_r + 4'h1;
	assign lineBase = 7'(int'(scanIdx_r) * LC);
	assign nextBase = 7'(int'(scanIdx_nxt) * LC);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lineCnt_r <= 8'h00;
		end else if (lineEnd) begin
			lineCnt_r <= 8'h00;
		end else if (tick) begin
			lineCnt_r <= lineCnt_r + 8'h01;
		end
	end

	// Register settings are copied into the working set only at the line boundary.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scanIdx_r     <= 4'h0;
			scanLast_r    <= lms_pkg::SCAN_ALL;
			rowForceAct_r <= 9'h000;
			rowMaskAct_r  <= 9'h000;
			slopeAct_r    <= lms_pkg::RST_SLOPE_TIME;
			melodyAct_r   <= lms_pkg::RST_MELODY_COMP;
		end else if (lineEnd) begin
			scanIdx_r     <= scanIdx_nxt;
			scanLast_r    <= scanLast_nxt;
			rowForceAct_r <= {rowForceUpper_r, 6'h00};
			rowMaskAct_r  <= {rowMaskUpper_r, rowMaskLower_r};
			slopeAct_r    <= slopeCtrl_r;
			melodyAct_r   <= melodyComp_r;
		end
	end

	// Fade and firefly stepping for the nine LEDs of the line that is ending.
	always_comb begin
		for (int c = 0; c < LC; c++) begin
			logic [6:0] i;
			i = 7'(lineBase + 7'(c));
			baseSteps[c] = lms_pkg::lms_step_frames(brightMem[i][2:0]);
			curDuty_nxt[c] = curDuty_r[i];
			phase_nxt[c] = phase_r[i];
			if (ledPwmEnable[i]) begin
				waitLen[c] = (dutyMem[i] < curDuty_r[i] && slopeAct_r[lms_pkg::FADE_DOUBLE_BIT]) ?
					6'(baseSteps[c] << 1) : baseSteps[c];
			end else begin
				case (phase_r[i])
					lms_pkg::PH_HIGH: waitLen[c] = lms_pkg::lms_scale(baseSteps[c],
						slopeAct_r[lms_pkg::HIGH_EXT_LSB +: 2]);
					lms_pkg::PH_LOW: waitLen[c] = lms_pkg::lms_scale(baseSteps[c],
						slopeAct_r[lms_pkg::LOW_EXT_LSB +: 2]);
					lms_pkg::PH_FALL: waitLen[c] = slopeAct_r[lms_pkg::FADE_DOUBLE_BIT] ?
						6'(baseSteps[c] << 1) : baseSteps[c];
					default: waitLen[c] = baseSteps[c];
				endcase
			end
			stepCnt_nxt[c] = stepCnt_r[i] + 6'h01;
			if (baseSteps[c] == 6'h00) begin
				stepCnt_nxt[c] = 6'h00;
				phase_nxt[c] = lms_pkg::PH_RISE;
				curDuty_nxt[c] = ledPwmEnable[i] ? dutyMem[i] : 8'h00;
			end else if (stepCnt_r[i] + 6'h01 >= waitLen[c]) begin
				stepCnt_nxt[c] = 6'h00;
				if (ledPwmEnable[i]) begin
					if (curDuty_r[i] < dutyMem[i]) begin
						curDuty_nxt[c] = curDuty_r[i] + 8'h01;
					end else if (curDuty_r[i] > dutyMem[i]) begin
						curDuty_nxt[c] = curDuty_r[i] - 8'h01;
					end
				end else begin
					case (phase_r[i])
						lms_pkg::PH_RISE: begin
							curDuty_nxt[c] = curDuty_r[i] + 8'h01;
							if (curDuty_r[i] == 8'hfe) phase_nxt[c] = lms_pkg::PH_HIGH;
						end
						lms_pkg::PH_HIGH: phase_nxt[c] = lms_pkg::PH_FALL;
						lms_pkg::PH_FALL: begin
							curDuty_nxt[c] = curDuty_r[i] - 8'h01;
							if (curDuty_r[i] == 8'h01) phase_nxt[c] = lms_pkg::PH_LOW;
						end
						default: phase_nxt[c] = lms_pkg::PH_RISE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < LN; i++) begin
				curDuty_r[i] <= 8'h00;
				stepCnt_r[i] <= 6'h00;
				phase_r[i]   <= lms_pkg::PH_RISE;
			end
		end else if (lineEnd) begin
			for (int c = 0; c < LC; c++) begin
				curDuty_r[7'(lineBase + 7'(c))] <= curDuty_nxt[c];
				stepCnt_r[7'(lineBase + 7'(c))] <= stepCnt_nxt[c];
				phase_r[7'(lineBase + 7'(c))]   <= phase_nxt[c];
			end
		end
	end

	// Column sink request resolved in mode priority order.
	always_comb begin
		for (int c = 0; c < LC; c++) begin
			logic [6:0] i;
			logic       pwmOn;
			i = 7'(lineBase + 7'(c));
			pwmOn = (8'(lineCnt_r - lms_pkg::BLANK_CLKS) < curDuty_r[i]);
			if (!matrixEnable || blank) begin
				sinkReq[c] = 1'b0;
			end else if (colConstMode[c]) begin
				sinkReq[c] = 1'b1;
			end else if (rowMaskAct_r[scanIdx_r]) begin
				sinkReq[c] = 1'b0;
			end else if (rowForceAct_r[scanIdx_r]) begin
				sinkReq[c] = 1'b1;
			end else if (ledPwmEnable[i] || brightMem[i][2:0] != 3'h0) begin
				sinkReq[c] = pwmOn;
			end else begin
				sinkReq[c] = 1'b1;
			end
		end
	end

	// Mask wins over force; unmasked forced rows stay on through blanking.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rowSwitchOn <= 9'h000;
		end else begin
			for (int r = 0; r < LC; r++) begin
				rowSwitchOn[r] <= matrixEnable && !rowMaskAct_r[r] &&
					(rowForceAct_r[r] || (4'(r) == scanIdx_r && !blank));
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			colCurrentCode <= 36'h0;
		end else if (lineEnd) begin
			for (int c = 0; c < LC; c++) begin
				colCurrentCode[c*4 +: 4] <=
					brightMem[7'(nextBase + 7'(c))][lms_pkg::BRIGHT_LSB +: 4];
			end
		end
	end

	assign extendCycles = melodyMode ? 10'(int'(melodyAct_r) * lms_pkg::COMP_STEP_CYC) : 10'h000;

	genvar g;
	generate
		for (g = 0; g < LC; g++) begin : gen_col
			lms_on_stretch u_stretch (
				.core_clk     (core_clk),
				.rst_n        (rst_n),
				.req          (sinkReq[g]),
				.extendCycles (extendCycles),
				.on           (colSinkOn[g])
			);
		end
	endgenerate

	sequence s_slope_wr;
		regWrEn && regAddr == lms_pkg::ADDR_SLOPE_TIME;
	endsequence
	sequence s_slope_rd;
		!regWrEn && regAddr == lms_pkg::ADDR_SLOPE_TIME;
	endsequence
	property p_slope_readback;
		@(posedge core_clk) disable iff (!rst_n)
		s_slope_wr ##1 s_slope_rd |=> regRdData == ($past(regWrData, 2) & 8'h1f);
	endproperty
	a_slope_readback: assert property (p_slope_readback) else $error("slope readback wrong");

	property p_line_wrap;
		@(posedge core_clk) disable iff (!rst_n)
		lineEnd |=> lineCnt_r == 8'h00 ##1 lineCnt_r <= 8'h01;
	endproperty
	a_line_wrap: assert property (p_line_wrap) else $error("line length wrong");

	property p_blank_rows;
		@(posedge core_clk) disable iff (!rst_n)
		blank && rowForceAct_r == 9'h000 |=> rowSwitchOn == 9'h000;
	endproperty
	a_blank_rows: assert property (p_blank_rows) else $error("row on during blanking");

	property p_mask_off;
		@(posedge core_clk) disable iff (!rst_n)
		##1 (rowSwitchOn & $past(rowMaskAct_r)) == 9'h000;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("masked row switched on");

	property p_force_on;
		@(posedge core_clk) disable iff (!rst_n)
		matrixEnable && rowForceAct_r[8] && !rowMaskAct_r[8] |=> rowSwitchOn[8];
	endproperty
	a_force_on: assert property (p_force_on) else $error("forced row not on");

	property p_scan_wrap;
		@(posedge core_clk) disable iff (!rst_n)
		lineEnd && scanIdx_r >= scanLast_r |=> scanIdx_r == 4'h0;
	endproperty
	a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap");

	property p_scan_clamp;
		@(posedge core_clk) disable iff (!rst_n)
		lineEnd && scanCount_r > lms_pkg::SCAN_ALL |=> scanLast_r == lms_pkg::SCAN_ALL;
	endproperty
	a_scan_clamp: assert property (p_scan_clamp) else $error("scan count not clamped");

	property p_fade_step;
		@(posedge core_clk) disable iff (!rst_n)
		$past(brightMem[0][2:0]) != 3'h0 && $changed(curDuty_r[0]) |->
			(curDuty_r[0] == $past(curDuty_r[0]) + 8'h01 ||
			curDuty_r[0] == $past(curDuty_r[0]) - 8'h01);
	endproperty
	a_fade_step: assert property (p_fade_step) else $error("fade moved more than one code");

	property p_matrix_off;
		@(posedge core_clk) disable iff (!rst_n)
		!matrixEnable |-> sinkReq == 9'h000 ##1 rowSwitchOn == 9'h000;
	endproperty
	a_matrix_off: assert property (p_matrix_off) else $error("output active with matrix off");
endmodule

/* File: rtl/lms_tick_gen.sv */
// Matrix timing tick from the internal divider or from an external clock input.
module lms_tick_gen (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic extClkSel,
	input  wire logic extClkIn,
	output logic      tick
);
	logic [4:0] divCnt_r;
	logic       extPrev_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_r <= 5'h00;
		end else if (divCnt_r == 5'(lms_pkg::INT_TICK_DIV - 1)) begin
			divCnt_r <= 5'h00;
		end else begin
			divCnt_r <= divCnt_r + 5'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			extPrev_r <= 1'b0;
		end else begin
			extPrev_r <= extClkIn;
		end
	end

	// The internal divider is the default source; the external rising edge replaces it.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 1'b0;
		end else if (extClkSel) begin
			tick <= extClkIn & ~extPrev_r;
		end else begin
			tick <= (divCnt_r == 5'(lms_pkg::INT_TICK_DIV - 1));
		end
	end
endmodule

/* File: tb/lms_matrix_model.sv */
// Behavioural LED matrix: an LED lights where its row switch and column sink are both on.
module lms_matrix_model (
	input  wire logic [8:0]  rowSwitchOn,
	input  wire logic [8:0]  colSinkOn,
	output logic      [80:0] litLeds
);
	timeunit 1ns;
	timeprecision 100ps;
	always_comb begin
		for (int r = 0; r < 9; r++) begin
			for (int c = 0; c < 9; c++) begin
				litLeds[r*9+c] = rowSwitchOn[r] & colSinkOn[c];
			end
		end
	end
endmodule

/* File: tb/test_lms_scan_ctrl.sv */
// Self-checking bench for the LED matrix scan controller.
module test_lms_scan_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk     = 1'b0;
	logic        rst_n        = 1'b0;
	logic        regWrEn      = 1'b0;
	logic [7:0]  regAddr      = 8'h00;
	logic [7:0]  regWrData    = 8'h00;
	logic [7:0]  regRdData;
	logic        matrixEnable = 1'b1;
	logic [8:0]  colConstMode = 9'h000;
	logic [80:0] ledPwmEnable = '0;
	logic        extClkSel    = 1'b1;
	logic        extClkIn     = 1'b0;
	logic        melodyMode   = 1'b0;
	logic [8:0]  rowSwitchOn;
	logic [8:0]  colSinkOn;
	logic [35:0] colCurrentCode;
	logic [80:0] litLeds;
	logic [8:0]  orRows;
	logic [8:0]  andRows;
	logic [8:0]  orSinks;
	int          mismatches   = 0;
	int          testsRun     = 0;
	int          tickCyc      = 2;
	int          sinkCnt;
	int          rowCnt;
	int          multiRow;

	lms_scan_ctrl lms_scan_ctrl_inst (
		.core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData), .matrixEnable(matrixEnable),
		.colConstMode(colConstMode), .ledPwmEnable(ledPwmEnable), .extClkSel(extClkSel),
		.extClkIn(extClkIn), .melodyMode(melodyMode), .rowSwitchOn(rowSwitchOn),
		.colSinkOn(colSinkOn), .colCurrentCode(colCurrentCode)
	);
	lms_matrix_model lms_matrix_model_inst (
		.rowSwitchOn(rowSwitchOn), .colSinkOn(colSinkOn), .litLeds(litLeds)
	);

	always #12.5 core_clk = ~core_clk;
	// External matrix clock rises every second core cycle.
	always @(posedge core_clk) #2 extClkIn = ~extClkIn;

	task automatic wrap_up;
		if (mismatches == 0 && testsRun > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #2;
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(posedge core_clk) #2;
		regWrEn = 1'b0;
	endtask

	task automatic regCheck(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk) #2;
		regAddr = a;
		repeat (2) @(posedge core_clk);
		#2;
		check({8'h00, regRdData}, {8'h00, exp});
	endtask

	// Lets settings latch for some lines, then gathers row and sink activity.
	task automatic observe(input int waitLines, input int nLines);
		repeat (waitLines * 255 * tickCyc) @(posedge core_clk);
		orRows = '0;
		andRows = '1;
		orSinks = '0;
		sinkCnt = 0;
		rowCnt = 0;
		multiRow = 0;
		repeat (nLines * 255 * tickCyc) begin
			@(posedge core_clk) #2;
			orRows |= rowSwitchOn;
			andRows &= rowSwitchOn;
			orSinks |= colSinkOn;
			sinkCnt += (litLeds[0] === 1'b1 || colSinkOn[0] === 1'b1) ? 1 : 0;
			rowCnt += (rowSwitchOn[0] === 1'b1) ? 1 : 0;
			multiRow += ($countones(rowSwitchOn) > 1) ? 1 : 0;
		end
	endtask

	task automatic testResetValues;
		logic [7:0] a [9] = '{8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h36, 8'h40, 8'h91, 8'h34};
		logic [7:0] e [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h08, 8'h00, 8'h00, 8'h00};
		foreach (a[i]) begin
			regCheck(a[i], e[i]);
		end
	endtask

	task automatic testRegAccess;
		logic [7:0] a [10] = '{8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h36, 8'h90, 8'he1, 8'h34,
			8'he2};
		logic [7:0] e [10] = '{8'h07, 8'h3f, 8'h07, 8'h1f, 8'h07, 8'h0f, 8'hff, 8'hf7, 8'h00,
			8'h00};
		foreach (a[i]) begin
			regWrite(a[i], 8'hff);
			regCheck(a[i], e[i]);
			regWrite(a[i], 8'h00);
		end
		regWrite(lms_pkg::ADDR_MELODY_COMP, 8'h03);
		regWrite(lms_pkg::ADDR_SCAN_COUNT, 8'h08);
	endtask

	task automatic testScanCount;
		regWrite(lms_pkg::ADDR_SCAN_COUNT, 8'h01);
		observe(10, 9);
		check({7'h00, orRows}, 16'h0003);
		check(16'(multiRow), 16'h0000);
		regWrite(lms_pkg::ADDR_SCAN_COUNT, 8'h0f);
		observe(10, 9);
		check({7'h00, orRows}, 16'h01ff);
		regWrite(lms_pkg::ADDR_SCAN_COUNT, 8'h08);
	endtask

	task automatic testRowOverride;
		regWrite(lms_pkg::ADDR_ROW_FORCE_UPPER, 8'h07);
		regWrite(lms_pkg::ADDR_ROW_MASK_LOWER, 8'h3f);
		observe(2, 9);
		check({13'h0000, andRows[8:6]}, 16'h0007);
		check({10'h000, orRows[5:0]}, 16'h0000);
		regWrite(lms_pkg::ADDR_ROW_MASK_UPPER, 8'h07);
		observe(2, 9);
		check({7'h00, orRows}, 16'h0000);
		regWrite(lms_pkg::ADDR_ROW_FORCE_UPPER, 8'h00);
		regWrite(lms_pkg::ADDR_ROW_MASK_LOWER, 8'h00);
		regWrite(lms_pkg::ADDR_ROW_MASK_UPPER, 8'h00);
		matrixEnable = 1'b0;
		observe(1, 2);
		check({orRows, orSinks[6:0]}, 16'h0000);
		matrixEnable = 1'b1;
	endtask

	task automatic measureLine(input logic [7:0] duty, input int expSink);
		regWrite(lms_pkg::ADDR_DUTY_FIRST, duty);
		// A single scanned line may need two boundaries to settle before its own line ends.
		observe(3, 1);
		check(16'(sinkCnt), 16'(expSink));
	endtask

	task automatic testDuty;
		regWrite(lms_pkg::ADDR_SCAN_COUNT, 8'h00);
		regWrite(lms_pkg::ADDR_BRIGHT_FIRST, 8'ha0);
		ledPwmEnable[0] = 1'b1;
		measureLine(8'h80, 128 * tickCyc);
		check(16'(rowCnt), 16'(251 * tickCyc));
		check({12'h000, colCurrentCode[3:0]}, 16'h000a);
		measureLine(8'h00, 0);
		colConstMode[0] = 1'b1;
		measureLine(8'h00, 251 * tickCyc);
		colConstMode[0] = 1'b0;
		melodyMode = 1'b1;
		measureLine(8'h80, 128 * tickCyc + 3 * lms_pkg::COMP_STEP_CYC);
		regWrite(lms_pkg::ADDR_MELODY_COMP, 8'h01);
		measureLine(8'h80, 128 * tickCyc + lms_pkg::COMP_STEP_CYC);
		melodyMode = 1'b0;
		ledPwmEnable[0] = 1'b0;
		measureLine(8'h80, 251 * tickCyc);
		regWrite(lms_pkg::ADDR_DUTY_FIRST, 8'h00);
		ledPwmEnable[0] = 1'b1;
		regWrite(lms_pkg::ADDR_BRIGHT_FIRST, 8'ha1);
		regWrite(lms_pkg::ADDR_DUTY_FIRST, 8'h04);
		observe(0, 1);
		check(16'(sinkCnt <= 2 * tickCyc), 16'h0001);
		observe(10, 1);
		check(16'(sinkCnt), 16'(4 * tickCyc));
		ledPwmEnable[0] = 1'b0;
		observe(0, 1);
		check(16'(sinkCnt >= 4 * tickCyc && sinkCnt <= 5 * tickCyc), 16'h0001);
		ledPwmEnable[0] = 1'b1;
		regWrite(lms_pkg::ADDR_BRIGHT_FIRST, 8'ha0);
		extClkSel = 1'b0;
		tickCyc = 16;
		ledPwmEnable[0] = 1'b1;
		measureLine(8'h40, 64 * tickCyc);
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		#2;
		rst_n = 1'b1;
		testResetValues();
		testRegAccess();
		testScanCount();
		testRowOverride();
		testDuty();
		wrap_up();
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		mismatches++;
		wrap_up();
	end
endmodule
